/* File: scrb_pkg.sv */
// Package for the safety configuration register bank
package scrb_pkg;
  // ---------------------------------------------------------------
  // Register selection codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_LOW_PHASE = 2'h0;
  localparam logic [1:0] SEL_THRESHOLD = 2'h1;
  localparam logic [1:0] SEL_CHECKSUM = 2'h2;
  localparam logic [1:0] SEL_DIAGNOSTIC_OUTPUT_CONTROL = 2'h3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LOW_PHASE_RESET = 8'h3C;
  localparam logic [3:0] LIMIT_RESET = 4'hF;
  localparam logic PWROFF_EN_RESET = 1'b0;
  localparam logic [7:0] CHECKSUM_RESET = 8'h96;
  localparam logic [7:0] DIAGNOSTIC_OUTPUT_CONTROL_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PWROFF_EN_BIT = 4;
  localparam int MUX_EN_BIT = 7;
  localparam int SERIAL_OUT_BIT = 6;
  localparam int MANUAL_OUT_BIT = 5;
  localparam int INTCON_LSB = 2;
  localparam int MUXCFG_LSB = 0;
  // ---------------------------------------------------------------
  // Mux modes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] MUX_MANUAL = 2'h0;
  localparam logic [1:0] MUX_DIGITAL = 2'h1;
  localparam logic [1:0] MUX_ANALOG = 2'h2;
  localparam logic [1:0] MUX_INTERCONNECT = 2'h3;
  localparam int LOW_PHASE_STEP_US = 15;
  localparam int CLK_MHZ = 40;
  localparam int LOW_PHASE_STEP_CYC = LOW_PHASE_STEP_US * CLK_MHZ;
  typedef struct packed {
    logic wrEn;
    logic [1:0] sel;
    logic [7:0] data;
  } scrb_wr_t;
endpackage

/* File: scrb_bank.sv */
// Safety configuration register bank
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Config writes only in diagnostic, unlocked
// - Diag control writes only when unlocked
// - Low-phase minimum is (value+1)*15us, reset 3C
// - Enabled count match forces OFF state
// - 4-bit limit resets F, bits 7-5 zero
// - Keep 8-bit expected configuration checksum
// - Checksum resets to 96 after wake-up
// - Output enable off tri-states diagnostic pin
// - Mux field selects manual, digital, analog, interconnect
module scrb_bank
  import scrb_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic reset, // Power-on reset, sync high
  input wire logic deviceReset, // Device reset, sync high
  input wire scrb_wr_t wrReq, // Write command
  input wire logic [1:0] rdSel, // Read select
  input wire logic inDiagState, // Device in diagnostic state
  input wire logic configLock, // Configuration lock bit
  input wire logic controlLock, // Control lock bit
  input wire logic [3:0] device_error_counter, // Device error count
  input wire logic digitalMux, // Digital mux result
  input wire logic analogMux, // Analog mux comparator result
  input wire logic interconnectIn, // Selected interconnect input
  output logic [7:0] rdData, // Read data
  output logic [7:0] low_phase_min_count, // Low-phase minimum field
  output logic [17:0] lowPhaseMinCycles, // Low-phase minimum in cycles
  output logic [7:0] expected_config_checksum_value, // Expected checksum
  output logic forceOff, // Request OFF state
  output logic [2:0] interconnect_test_select, // Interconnect selector
  output logic serial_out_test_level, // Serial out test level
  output logic diagnostic_output_pin, // Diagnostic pin data
  output logic diagOutEnable_n // Diagnostic pin enable, low drives
);
  logic [7:0] lowPhase_ff;
  logic [3:0] limit_ff;
  logic pwrOffEn_ff;
  logic [7:0] checksum_ff;
  logic [7:0] diagCtrl_ff;
  logic cfgWrOk;
  logic ctlWrOk;
  logic muxBit;
  logic [7:0] nxt_rdData;

  assign cfgWrOk = wrReq.wrEn && inDiagState && !configLock;
  assign ctlWrOk = wrReq.wrEn && !controlLock && wrReq.sel == SEL_DIAGNOSTIC_OUTPUT_CONTROL;

  // ---------------------------------------------------------------
  // Safety configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      lowPhase_ff <= LOW_PHASE_RESET;
      limit_ff <= LIMIT_RESET;
      pwrOffEn_ff <= PWROFF_EN_RESET;
      checksum_ff <= CHECKSUM_RESET;
    end else if (cfgWrOk) begin
      case (wrReq.sel)
        SEL_LOW_PHASE: lowPhase_ff <= wrReq.data;
        SEL_THRESHOLD: begin
          limit_ff <= wrReq.data[3:0];
          pwrOffEn_ff <= wrReq.data[PWROFF_EN_BIT];
        end
        SEL_CHECKSUM: checksum_ff <= wrReq.data;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Diagnostic control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || deviceReset) begin
      diagCtrl_ff <= DIAGNOSTIC_OUTPUT_CONTROL_RESET;
    end else if (ctlWrOk) begin
      diagCtrl_ff <= wrReq.data;
    end
  end

  // ---------------------------------------------------------------
  // Derived outputs
  // ---------------------------------------------------------------
  always_comb begin
    case (diagCtrl_ff[MUXCFG_LSB +: 2])
      MUX_MANUAL: muxBit = diagCtrl_ff[MANUAL_OUT_BIT];
      MUX_DIGITAL: muxBit = digitalMux;
      MUX_ANALOG: muxBit = analogMux;
      default: muxBit = interconnectIn;
    endcase
    case (rdSel)
      SEL_LOW_PHASE: nxt_rdData = lowPhase_ff;
      SEL_THRESHOLD: nxt_rdData = {3'h0, pwrOffEn_ff, limit_ff};
      SEL_CHECKSUM: nxt_rdData = checksum_ff;
      default: nxt_rdData = diagCtrl_ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdData <= 8'h00;
      low_phase_min_count <= LOW_PHASE_RESET;
      lowPhaseMinCycles <= 18'h00000;
      expected_config_checksum_value <= CHECKSUM_RESET;
      forceOff <= 1'b0;
      interconnect_test_select <= 3'h0;
      serial_out_test_level <= 1'b0;
      diagnostic_output_pin <= 1'b0;
      diagOutEnable_n <= 1'b1;
    end else begin
      rdData <= nxt_rdData;
      low_phase_min_count <= lowPhase_ff;
      // Field FF gives 153600 cycles, hence 18 bits
      lowPhaseMinCycles <= 18'((10'(lowPhase_ff) + 10'h001) * LOW_PHASE_STEP_CYC);
      expected_config_checksum_value <= checksum_ff;
      forceOff <= pwrOffEn_ff && (device_error_counter == limit_ff);
      interconnect_test_select <= diagCtrl_ff[INTCON_LSB +: 3];
      serial_out_test_level <= diagCtrl_ff[SERIAL_OUT_BIT];
      diagnostic_output_pin <= diagCtrl_ff[MUX_EN_BIT] ? muxBit : 1'b0;
      diagOutEnable_n <= !diagCtrl_ff[MUX_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // Write acceptance
  // ---------------------------------------------------------------
  a_cfg_locked_hold: assert property (
    (configLock || !inDiagState) |=> $stable(lowPhase_ff) && $stable(checksum_ff)
    && $stable(limit_ff) && $stable(pwrOffEn_ff))
    else $error("config register changed while locked");
  a_cfg_write_take: assert property (
    cfgWrOk && wrReq.sel == SEL_CHECKSUM |=> checksum_ff == $past(wrReq.data))
    else $error("checksum write lost");
  a_low_write_take: assert property (
    cfgWrOk && wrReq.sel == SEL_LOW_PHASE |=> lowPhase_ff == $past(wrReq.data))
    else $error("low phase write lost");
  a_limit_write_take: assert property (
    cfgWrOk && wrReq.sel == SEL_THRESHOLD |=> limit_ff == $past(wrReq.data[3:0])
    && pwrOffEn_ff == $past(wrReq.data[PWROFF_EN_BIT]))
    else $error("threshold write lost");
  a_ctl_locked_hold: assert property (
    controlLock && !deviceReset |=> $stable(diagCtrl_ff))
    else $error("diag control changed while locked");
  a_ctl_write_take: assert property (
    ctlWrOk && !deviceReset |=> diagCtrl_ff == $past(wrReq.data))
    else $error("diag control write lost");
  a_dev_reset: assert property (deviceReset |=> diagCtrl_ff == DIAGNOSTIC_OUTPUT_CONTROL_RESET)
    else $error("diag control not cleared");
  // ---------------------------------------------------------------
  // OFF request and readback
  // ---------------------------------------------------------------
  a_off_request: assert property (
    pwrOffEn_ff && device_error_counter == limit_ff |=> forceOff)
    else $error("OFF request missing");
  a_off_disabled: assert property (!pwrOffEn_ff |=> !forceOff)
    else $error("OFF request while disabled");
  a_off_mismatch: assert property (device_error_counter != limit_ff |=> !forceOff)
    else $error("OFF request without count match");
  a_limit_read: assert property (rdSel == SEL_THRESHOLD |=> rdData[7:5] == 3'h0)
    else $error("reserved bits not zero");
  a_read_limit: assert property (
    rdSel == SEL_THRESHOLD |=> rdData[4:0] == $past({pwrOffEn_ff, limit_ff}))
    else $error("threshold readback wrong");
  a_read_low: assert property (
    rdSel == SEL_LOW_PHASE |=> rdData == $past(lowPhase_ff))
    else $error("low phase readback wrong");
  a_read_checksum: assert property (
    rdSel == SEL_CHECKSUM |=> rdData == $past(checksum_ff))
    else $error("checksum readback wrong");
  a_read_ctrl: assert property (
    rdSel == SEL_DIAGNOSTIC_OUTPUT_CONTROL |=> rdData == $past(diagCtrl_ff))
    else $error("diag control readback wrong");
  a_low_copy: assert property (1'b1 |=> low_phase_min_count == $past(lowPhase_ff))
    else $error("low phase copy wrong");
  a_low_cycles: assert property (
    1'b1 |=> lowPhaseMinCycles == 18'($past(lowPhase_ff)) * 18'(LOW_PHASE_STEP_CYC)
    + 18'(LOW_PHASE_STEP_CYC))
    else $error("low phase cycles wrong");
  a_checksum_copy: assert property (
    1'b1 |=> expected_config_checksum_value == $past(checksum_ff))
    else $error("checksum copy wrong");
  // ---------------------------------------------------------------
  // Diagnostic pin
  // ---------------------------------------------------------------
  a_pin_tristate: assert property (!diagCtrl_ff[MUX_EN_BIT] |=> diagOutEnable_n)
    else $error("pin driven while disabled");
  a_pin_quiet: assert property (!diagCtrl_ff[MUX_EN_BIT] |=> !diagnostic_output_pin)
    else $error("pin data while disabled");
  a_pin_driven: assert property (diagCtrl_ff[MUX_EN_BIT] |=> !diagOutEnable_n)
    else $error("pin not driven while enabled");
  a_manual_out: assert property (
    diagCtrl_ff[MUX_EN_BIT] && diagCtrl_ff[1:0] == MUX_MANUAL
    |=> diagnostic_output_pin == $past(diagCtrl_ff[MANUAL_OUT_BIT]))
    else $error("manual output wrong");
  a_mux_digital: assert property (
    diagCtrl_ff[MUX_EN_BIT] && diagCtrl_ff[1:0] == MUX_DIGITAL
    |=> diagnostic_output_pin == $past(digitalMux))
    else $error("digital mux output wrong");
  a_mux_analog: assert property (
    diagCtrl_ff[MUX_EN_BIT] && diagCtrl_ff[1:0] == MUX_ANALOG
    |=> diagnostic_output_pin == $past(analogMux))
    else $error("analog mux output wrong");
  a_mux_interconnect: assert property (
    diagCtrl_ff[MUX_EN_BIT] && diagCtrl_ff[1:0] == MUX_INTERCONNECT
    |=> diagnostic_output_pin == $past(interconnectIn))
    else $error("interconnect output wrong");
  a_diag_fields: assert property (
    1'b1 |=> interconnect_test_select == $past(diagCtrl_ff[INTCON_LSB +: 3])
    && serial_out_test_level == $past(diagCtrl_ff[SERIAL_OUT_BIT]))
    else $error("diag field copy wrong");

  c_cfg_write: cover property (cfgWrOk && wrReq.sel == SEL_LOW_PHASE);
  c_force_off: cover property (forceOff);
  c_pin_driven: cover property (!diagOutEnable_n);
  c_interconnect: cover property (diagCtrl_ff[1:0] == MUX_INTERCONNECT);
  c_locked_write: cover property (wrReq.wrEn && controlLock && wrReq.sel == SEL_DIAGNOSTIC_OUTPUT_CONTROL);
endmodule
`default_nettype wire

/* File: scrb_mcu.sv */
// Microcontroller model issuing register writes
`timescale 1ns/1ps
`default_nettype none
module scrb_mcu
  import scrb_pkg::*;
(
  input wire logic clk, // Bench clock
  output var scrb_wr_t wrReq // Write command
);
  initial wrReq = '0;
  // ---------------------------------------------------------------
  // One-cycle write strobe
  // ---------------------------------------------------------------
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    #2 wrReq = '{wrEn: 1'b1, sel: s, data: d};
    @(posedge clk);
    #2 wrReq.wrEn = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_scrb_bank.sv */
// Testbench for the safety configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_scrb_bank
  import scrb_pkg::*;
();
  logic clk = 1'b0, reset = 1'b1, deviceReset = 1'b0, inDiagState = 1'b0, pend = 1'b0;
  logic configLock = 1'b0, controlLock = 1'b0, digitalMux = 1'b0, analogMux = 1'b0;
  logic interconnectIn = 1'b0, forceOff, diagnostic_output_pin, diagOutEnable_n;
  logic serial_out_test_level;
  logic [1:0] rdSel = 2'h0;
  logic [2:0] interconnect_test_select;
  logic [3:0] device_error_counter = 4'h0;
  logic [4:0] b;
  logic [7:0] rdData, v, low_phase_min_count, expected_config_checksum_value;
  logic [17:0] lowPhaseMinCycles;
  logic [17:0] obs [4];
  logic [19:0] q [$];
  logic [19:0] e;
  int err_count = 0, comparisons = 0, ticks = 0;
  scrb_wr_t wrReq;
  scrb_mcu i_scrb_mcu (.clk, .wrReq);
  scrb_bank i_scrb_bank (.clk, .reset, .deviceReset, .wrReq, .rdSel, .inDiagState,
    .configLock, .controlLock, .device_error_counter, .digitalMux, .analogMux,
    .interconnectIn, .rdData, .low_phase_min_count, .lowPhaseMinCycles,
    .expected_config_checksum_value, .forceOff, .interconnect_test_select,
    .serial_out_test_level, .diagnostic_output_pin, .diagOutEnable_n);
  assign obs[0] = {10'h000, rdData};
  assign obs[1] = lowPhaseMinCycles;
  assign obs[2] = {12'h000, serial_out_test_level, interconnect_test_select, diagOutEnable_n,
    diagnostic_output_pin};
  assign obs[3] = {1'b0, expected_config_checksum_value, low_phase_min_count, forceOff};
  initial forever #12.5 clk = ~clk;
  // ---------------------------------------------------------------
  // Note taking and result watching
  // ---------------------------------------------------------------
  task automatic chk(input logic [1:0] w, input logic [17:0] x);
    @(posedge clk);
    #2 pend = 1'b1;
    q.push_back({w, x});
    @(posedge clk);
    #2 pend = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] x);
    @(posedge clk);
    #2 rdSel = s;
    chk(2'h0, {10'h000, x});
  endtask
  always @(negedge clk) begin
    if (pend) begin
      e = q.pop_front();
      comparisons++;
      if (obs[e[19:18]] !== e[17:0]) begin
        err_count++;
        $display("unexpected obs%0d expected %h seen %h", e[19:18], e[17:0], obs[e[19:18]]);
      end
    end
  end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      err_count++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h9E5C));
    repeat (12) @(posedge clk);
    #2 reset = 1'b0;
    device_error_counter = 4'($urandom());
    v = 8'($urandom());
    rd(SEL_LOW_PHASE, 8'h3C);
    rd(SEL_THRESHOLD, 8'h0F);
    rd(SEL_CHECKSUM, 8'h96);
    rd(SEL_DIAGNOSTIC_OUTPUT_CONTROL, 8'h00);
    chk(2'h1, 18'h08EF8);
    chk(2'h2, 18'h00002);
    chk(2'h3, {1'b0, 8'h96, 8'h3C, 1'b0});
    i_scrb_mcu.wr(SEL_LOW_PHASE, v);
    rd(SEL_LOW_PHASE, 8'h3C);
    inDiagState = 1'b1;
    configLock = 1'b1;
    controlLock = 1'b1;
    i_scrb_mcu.wr(SEL_CHECKSUM, v);
    i_scrb_mcu.wr(SEL_DIAGNOSTIC_OUTPUT_CONTROL, 8'hFF);
    rd(SEL_CHECKSUM, 8'h96);
    rd(SEL_DIAGNOSTIC_OUTPUT_CONTROL, 8'h00);
    configLock = 1'b0;
    controlLock = 1'b0;
    i_scrb_mcu.wr(SEL_LOW_PHASE, v);
    rd(SEL_LOW_PHASE, v);
    chk(2'h1, (18'(v) + 18'h00001) * 18'h00258);
    i_scrb_mcu.wr(SEL_THRESHOLD, {4'hF, device_error_counter});
    rd(SEL_THRESHOLD, {4'h1, device_error_counter});
    chk(2'h3, {1'b0, 8'h96, v, 1'b1});
    device_error_counter = device_error_counter + 4'h1;
    chk(2'h3, {1'b0, 8'h96, v, 1'b0});
    i_scrb_mcu.wr(SEL_THRESHOLD, {4'h0, device_error_counter});
    chk(2'h3, {1'b0, 8'h96, v, 1'b0});
    i_scrb_mcu.wr(SEL_CHECKSUM, ~v);
    rd(SEL_CHECKSUM, ~v);
    chk(2'h3, {1'b0, ~v, v, 1'b0});
    inDiagState = 1'b0;
    for (int m = 0; m < 4; m++) begin
      b = 5'($urandom());
      {interconnectIn, analogMux, digitalMux} = b[2:0];
      i_scrb_mcu.wr(SEL_DIAGNOSTIC_OUTPUT_CONTROL, {1'b1, b[4], b[3], 3'(7 - m), 2'(m)});
      chk(2'h2, {12'h000, b[4], 3'(7 - m), 1'b0, ((m == 0) ? b[3] : b[m - 1])});
    end
    @(posedge clk);
    #2 deviceReset = 1'b1;
    @(posedge clk);
    #2 deviceReset = 1'b0;
    rd(SEL_DIAGNOSTIC_OUTPUT_CONTROL, 8'h00);
    chk(2'h2, 18'h00002);
    rd(SEL_CHECKSUM, ~v);
    reset = 1'b1;
    @(posedge clk);
    #2 reset = 1'b0;
    rd(SEL_CHECKSUM, 8'h96);
    chk(2'h3, {1'b0, 8'h96, 8'h3C, 1'b0});
    close_out();
  end
endmodule
`default_nettype wire
